// ==== dv/bacm_core_bus_model.sv ====
`timescale 1ns/1ps

module bacm_core_bus_model (
  // Clock
  input  wire logic                 i_core_clk,
  // Local bus cycle
  output logic                      o_lbus_valid,
  output logic [31:0]               o_lbus_addr,
  output logic [31:0]               o_lbus_data,
  output logic                      o_lbus_fetch,
  output logic                      o_lbus_write,
  output bacm_pkg::bacm_code_t      o_lbus_size,
  // Internal bus cycle
  output logic                      o_ibus_valid,
  output logic [31:0]               o_ibus_addr,
  output logic [31:0]               o_ibus_data,
  output logic                      o_ibus_fetch,
  output logic                      o_ibus_write,
  output bacm_pkg::bacm_code_t      o_ibus_size,
  output logic                      o_ibus_cpu
);
  import bacm_pkg::*;

  initial begin
    {o_lbus_valid, o_lbus_addr, o_lbus_data, o_lbus_fetch, o_lbus_write, o_lbus_size} = '0;
    {o_ibus_valid, o_ibus_addr, o_ibus_data, o_ibus_fetch, o_ibus_write, o_ibus_size} = '0;
    o_ibus_cpu = 1'b0;
  end

  // One cycle per call; gap 0 keeps the bus busy for back-to-back cycles
  task automatic cycle(input logic ib, input logic [31:0] a, input logic [31:0] d,
                       input logic f, input logic w, input bacm_code_t sz,
                       input logic cpu, input int gap);
    if (ib) begin
      {o_ibus_valid, o_ibus_addr, o_ibus_data, o_ibus_fetch, o_ibus_write, o_ibus_size,
       o_ibus_cpu} <= {1'b1, a, d, f, w, sz, cpu};
      o_lbus_valid <= 1'b0;
    end else begin
      {o_lbus_valid, o_lbus_addr, o_lbus_data, o_lbus_fetch, o_lbus_write, o_lbus_size}
        <= {1'b1, a, d, f, w, sz};
      o_ibus_valid <= 1'b0;
    end
    @(posedge i_core_clk);
    if (gap > 0) begin
      // Idle buses show the inverse so a stale cycle can never look valid
      {o_ibus_valid, o_lbus_valid} <= 2'b00;
      {o_ibus_addr, o_ibus_data} <= ~{o_ibus_addr, o_ibus_data};
      {o_lbus_addr, o_lbus_data} <= ~{o_lbus_addr, o_lbus_data};
      repeat (gap) @(posedge i_core_clk);
    end
  endtask
endmodule

// ==== dv/test_bacm_chan_a_match.sv ====
`timescale 1ns/1ps
`include "bacm_defs.svh"

module test_bacm_chan_a_match;
  import bacm_pkg::*;

  localparam logic [7:0] O_ADDR = 8'(`BACM_OFS_ADDR);
  localparam logic [7:0] O_AMSK = 8'(`BACM_OFS_AMASK);
  localparam logic [7:0] O_CTL  = 8'(`BACM_OFS_CYCCTL);
  localparam logic [7:0] O_DATA = 8'(`BACM_OFS_DATA);
  localparam logic [7:0] O_DMSK = 8'(`BACM_OFS_DMASK);
  localparam logic [7:0] O_STAT = 8'(`BACM_OFS_STATUS);
  localparam logic [1:0] OK     = `BACM_RESP_OKAY;
  localparam logic [1:0] ERR    = `BACM_RESP_SLVERR;
  localparam int         MAX_CYC = 20000;

  logic              i_core_clk = 1'b0;
  logic              rst_n      = 1'b0;
  logic [7:0]        aw_addr    = '0;
  logic              aw_v       = 1'b0;
  logic [31:0]       w_data     = '0;
  logic [3:0]        w_strb     = '0;
  logic              w_v        = 1'b0;
  logic              b_rdy      = 1'b0;
  logic [7:0]        ar_addr    = '0;
  logic              ar_v       = 1'b0;
  logic              r_rdy      = 1'b0;
  logic              seen_q     = 1'b0;
  int                error_cnt  = 0;
  int                tests_run  = 0;
  int                cyc        = 0;
  logic [33:0]       rq[$];
  logic [1:0]        bq[$];
  logic [1:0]        mq[$];
  logic              aw_rdy, w_rdy, b_v, ar_rdy, r_v, m_a, m_ib;
  logic [1:0]        b_resp, r_resp;
  logic [31:0]       r_data, la, ld, ia, id;
  logic              lv, lf, lw, iv, if_, iw, icpu;
  bacm_code_t        lsz, isz;

  always #50 i_core_clk = ~i_core_clk;

  bacm_core_bus_model u_core (
    .i_core_clk(i_core_clk), .o_lbus_valid(lv), .o_lbus_addr(la), .o_lbus_data(ld),
    .o_lbus_fetch(lf), .o_lbus_write(lw), .o_lbus_size(lsz), .o_ibus_valid(iv),
    .o_ibus_addr(ia), .o_ibus_data(id), .o_ibus_fetch(if_), .o_ibus_write(iw),
    .o_ibus_size(isz), .o_ibus_cpu(icpu));

  bacm_chan_a_match #(.ADDR_W(8)) dut (
    .i_core_clk(i_core_clk), .i_rst_n(rst_n),
    .i_s_axi_awaddr(aw_addr), .i_s_axi_awvalid(aw_v), .o_s_axi_awready(aw_rdy),
    .i_s_axi_wdata(w_data), .i_s_axi_wstrb(w_strb), .i_s_axi_wvalid(w_v),
    .o_s_axi_wready(w_rdy), .o_s_axi_bresp(b_resp), .o_s_axi_bvalid(b_v),
    .i_s_axi_bready(b_rdy), .i_s_axi_araddr(ar_addr), .i_s_axi_arvalid(ar_v),
    .o_s_axi_arready(ar_rdy), .o_s_axi_rdata(r_data), .o_s_axi_rresp(r_resp),
    .o_s_axi_rvalid(r_v), .i_s_axi_rready(r_rdy),
    .i_lbus_valid(lv), .i_local_address_bus(la), .i_local_data_bus(ld),
    .i_lbus_fetch(lf), .i_lbus_write(lw), .i_lbus_size(lsz),
    .i_ibus_valid(iv), .i_internal_address_bus(ia), .i_internal_data_bus(id),
    .i_ibus_fetch(if_), .i_ibus_write(iw), .i_ibus_size(isz), .i_ibus_cpu(icpu),
    .o_match_a(m_a), .o_match_on_ibus(m_ib));

  task automatic conclude();
    $display("Checks run: %0d, mismatches: %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic report(input logic [33:0] e, input logic [33:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic cmp_read(input logic [33:0] e, input logic [33:0] g);
    report(e, g);
  endtask

  task automatic cmp_resp(input logic [1:0] e, input logic [1:0] g);
    report(34'(e), 34'(g));
  endtask

  // The bus flag must stay low whenever no match is expected
  task automatic cmp_match(input logic [1:0] e, input logic [1:0] g);
    report(34'(e), 34'(g));
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] resp);
    logic pa, pw;
    bq.push_back(resp);
    {aw_addr, w_data, w_strb, aw_v, w_v} <= {a, d, s, 2'b11};
    pa = 1'b1;
    pw = 1'b1;
    while (pa | pw) begin
      @(posedge i_core_clk);
      pa = pa & (aw_rdy !== 1'b1);
      pw = pw & (w_rdy !== 1'b1);
      aw_v <= pa;
      w_v <= pw;
    end
    b_rdy <= 1'b1;
    do @(posedge i_core_clk); while (b_v !== 1'b1);
    b_rdy <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    rq.push_back({resp, d});
    {ar_addr, ar_v} <= {a, 1'b1};
    do @(posedge i_core_clk); while (ar_rdy !== 1'b1);
    {ar_v, r_rdy} <= 2'b01;
    do @(posedge i_core_clk); while (r_v !== 1'b1);
    r_rdy <= 1'b0;
  endtask

  task automatic bus(input logic ib, input logic [31:0] a, input logic [31:0] d,
                     input logic f, input logic w, input bacm_code_t sz, input logic cpu,
                     input logic exp, input int gap);
    mq.push_back({exp, exp & ib});
    u_core.cycle(ib, a, d, f, w, sz, cpu, gap);
  endtask

  function automatic logic qual(input bacm_cyc_ctrl_s c, input logic ib, input logic f,
                                input logic w, input bacm_code_t sz, input logic cpu);
    logic bus_ok;
    bus_ok = ib ? (c.bus == 2'h2 && c.master[0] && cpu) : (c.bus == 2'h1 || c.bus == 2'h3);
    return bus_ok && (f ? c.access[0] : c.access[1]) && (w ? c.dir[1] : c.dir[0])
           && (c.size == 2'h0 || c.size == sz);
  endfunction

  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == MAX_CYC) begin
      error_cnt++;
      conclude();
    end
    if (r_v === 1'b1 && r_rdy) cmp_read(rq.pop_front(), {r_resp, r_data});
    if (b_v === 1'b1 && b_rdy) cmp_resp(bq.pop_front(), b_resp);
    if (rst_n && seen_q) cmp_match(mq.pop_front(), {m_a, m_ib});
    else if (rst_n) cmp_match(2'b00, {m_a, m_ib});
    seen_q <= rst_n & (lv | iv);
  end

  initial begin
    bacm_cyc_ctrl_s c;
    logic [31:0] ad, dt, am, dm, fa, fd;
    logic ib;
    void'($urandom(50));
    repeat (16) @(posedge i_core_clk);
    rst_n <= 1'b1;
    @(posedge i_core_clk);
    for (int i = 0; i < 6; i++) axi_rd(8'(4 * i), `BACM_RST_WORD, OK);
    axi_wr(8'h18, $urandom, 4'hf, ERR);
    axi_rd(8'h1c, 32'h0, ERR);
    axi_rd(8'h20, 32'h0, ERR);
    dt = $urandom;
    axi_wr(O_DATA, dt, 4'hf, OK);
    axi_rd(O_DATA, dt, OK);
    axi_wr(O_DATA, ~dt, 4'h2, OK);
    axi_rd(O_DATA, {dt[31:16], ~dt[15:8], dt[7:0]}, OK);
    axi_wr(O_CTL, 32'hffff_ffff, 4'hf, OK);
    axi_rd(O_CTL, 32'(`BACM_CYCCTL_WMASK), OK);
    // Aligned break address keeps the size choice consistent
    ad = $urandom & 32'hffff_fffc;
    axi_wr(O_ADDR, ad, 4'hf, OK);
    axi_wr(O_AMSK, 32'h0, 4'hf, OK);
    for (int k = 0; k < 64; k++) begin
      c = '0;
      c.master = 3'h1;
      {c.bus, c.access, c.dir} = 6'(k);
      axi_wr(O_CTL, 32'(c), 4'h3, OK);
      for (int j = 0; j < 8; j++) begin
        ib = 1'($urandom);
        bus(j[2], ad, $urandom, j[1], j[0], 2'h3, ib, qual(c, j[2], j[1], j[0], 2'h3, ib),
            (j == 7) ? 2 : 0);
      end
    end
    dt = {16'($urandom), {2{8'($urandom)}}};
    axi_wr(O_DATA, dt, 4'hf, OK);
    axi_wr(O_DMSK, 32'h0, 4'hf, OK);
    for (int s = 0; s < 4; s++) begin
      c = {5'h0, 3'h1, 2'h1, 2'h3, 2'h3, 2'(s)};
      axi_wr(O_CTL, 32'(c), 4'h3, OK);
      for (int z = 1; z < 4; z++) begin
        bus(1'b0, ad, dt, 1'b0, 1'b1, 2'(z), 1'b0, (s == 0 || s == z), 1);
      end
    end
    // Last match above came from the local bus: seen set, internal flag clear
    axi_rd(O_STAT, 32'h1, OK);
    axi_wr(O_STAT, 32'h3, 4'h1, OK);
    axi_rd(O_STAT, 32'h0, OK);
    for (int n = 0; n < 32; n++) begin
      {am, dm, ib} = {32'($urandom), 32'($urandom), n[0]};
      fa = 32'h1 << ($urandom % 32);
      fd = 32'h1 << ($urandom % 32);
      axi_wr(O_AMSK, am, 4'hf, OK);
      axi_wr(O_DMSK, dm, 4'hf, OK);
      axi_wr(O_CTL, 32'({5'h0, 3'h1, ib ? 2'h2 : 2'h1, 6'h3f}), 4'h3, OK);
      axi_rd(O_DMSK, dm, OK);
      bus(ib, ad ^ fa, dt ^ fd, 1'($urandom), 1'($urandom), 2'h3, 1'b1,
          ((fa & ~am) == 0) && ((fd & ~dm) == 0), 1);
    end
    repeat (4) @(posedge i_core_clk);
    conclude();
  end
endmodule

// ==== logic/bacm_chan_a_match.sv ====
`timescale 1ns/1ps
`include "bacm_defs.svh"

// Notes on behaviour
// - Bus code 01/11 local, 10 internal
// - Access code: fetch, data, or either
// - Direction code: read, write, or both
// - Size code 00 ignores, else byte/word/long
// - Code 00 in bus/access/direction disables matching
// - Compare data word, read/write, resets zero
// - Bus choice also selects compared data bus
// - Data mask bit 1 excludes that bit
// - Address compared on selected address bus
// - Address mask bit 1 excludes that bit
module bacm_chan_a_match #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rst_n,
  // AXI4-Lite write channels
  input  wire logic [ADDR_W-1:0]    i_s_axi_awaddr,
  input  wire logic                 i_s_axi_awvalid,
  output logic                      o_s_axi_awready,
  input  wire logic [31:0]          i_s_axi_wdata,
  input  wire logic [3:0]           i_s_axi_wstrb,
  input  wire logic                 i_s_axi_wvalid,
  output logic                      o_s_axi_wready,
  output logic [1:0]                o_s_axi_bresp,
  output logic                      o_s_axi_bvalid,
  input  wire logic                 i_s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [ADDR_W-1:0]    i_s_axi_araddr,
  input  wire logic                 i_s_axi_arvalid,
  output logic                      o_s_axi_arready,
  output logic [31:0]               o_s_axi_rdata,
  output logic [1:0]                o_s_axi_rresp,
  output logic                      o_s_axi_rvalid,
  input  wire logic                 i_s_axi_rready,
  // Local bus cycle
  input  wire logic                 i_lbus_valid,
  input  wire logic [31:0]          i_local_address_bus,
  input  wire logic [31:0]          i_local_data_bus,
  input  wire logic                 i_lbus_fetch,
  input  wire logic                 i_lbus_write,
  input  wire bacm_pkg::bacm_code_t i_lbus_size,
  // Internal bus cycle
  input  wire logic                 i_ibus_valid,
  input  wire logic [31:0]          i_internal_address_bus,
  input  wire logic [31:0]          i_internal_data_bus,
  input  wire logic                 i_ibus_fetch,
  input  wire logic                 i_ibus_write,
  input  wire bacm_pkg::bacm_code_t i_ibus_size,
  input  wire logic                 i_ibus_cpu,
  // Match result
  output logic                      o_match_a,
  output logic                      o_match_on_ibus
);
  import bacm_pkg::*;

  if (ADDR_W < 6 || ADDR_W > 32) begin : g_chk
    $error("bacm_chan_a_match: ADDR_W must lie in 6..32");
  end

  // Register file and write channel state
  logic [31:0]    break_address_a_q, break_address_a_d;
  logic [31:0]    break_address_mask_a_q, break_address_mask_a_d;
  logic [15:0]    break_cycle_control_a_q, break_cycle_control_a_d;
  logic [31:0]    break_compare_data_a_q, break_compare_data_a_d;
  logic [31:0]    break_data_mask_a_q, break_data_mask_a_d;
  logic           seen_q, seen_d;
  logic           last_ibus_q, last_ibus_d;
  logic           aw_have_q, aw_have_d;
  logic [4:0]     aw_ofs_q, aw_ofs_d;
  logic           aw_far_q, aw_far_d;
  logic           w_have_q, w_have_d;
  logic [31:0]    wdata_q, wdata_d;
  logic [3:0]     wstrb_q, wstrb_d;
  logic           awready_q, awready_d;
  logic           wready_q, wready_d;
  logic           bvalid_q, bvalid_d;
  logic [1:0]     bresp_q, bresp_d;
  // Read channel state
  logic           arready_q, arready_d;
  logic           rvalid_q, rvalid_d;
  logic [31:0]    rdata_q, rdata_d;
  logic [1:0]     rresp_q, rresp_d;
  // Match state
  logic           match_q, match_d;
  logic           on_ibus_q, on_ibus_d;

  bacm_cyc_ctrl_s cc;
  logic           do_wr;
  logic [31:0]    status_word;
  logic           lq_ok, iq_ok, la_eq, ia_eq, ld_eq, id_eq;
  logic           lb_sel, ib_sel, data_on, lb_hit, ib_hit;

  assign cc          = bacm_cyc_ctrl_s'(break_cycle_control_a_q);
  assign status_word = {30'h0, last_ibus_q, seen_q};
  assign do_wr       = aw_have_q && w_have_q && !bvalid_q;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Write path: address and data are taken in either order, then one response
  always_comb begin
    break_address_a_d       = break_address_a_q;
    break_address_mask_a_d  = break_address_mask_a_q;
    break_cycle_control_a_d = break_cycle_control_a_q;
    break_compare_data_a_d  = break_compare_data_a_q;
    break_data_mask_a_d     = break_data_mask_a_q;
    aw_have_d               = aw_have_q;
    aw_ofs_d                = aw_ofs_q;
    aw_far_d                = aw_far_q;
    w_have_d                = w_have_q;
    wdata_d                 = wdata_q;
    wstrb_d                 = wstrb_q;
    bvalid_d                = bvalid_q;
    bresp_d                 = bresp_q;
    // Hardware set wins over a clear in the same cycle
    seen_d                  = seen_q;
    last_ibus_d             = last_ibus_q;
    if (i_s_axi_awvalid && awready_q) begin
      aw_have_d = 1'b1;
      aw_ofs_d  = {i_s_axi_awaddr[4:2], 2'b00};
      aw_far_d  = |i_s_axi_awaddr[ADDR_W-1:5];
    end
    if (i_s_axi_wvalid && wready_q) begin
      w_have_d = 1'b1;
      wdata_d  = i_s_axi_wdata;
      wstrb_d  = i_s_axi_wstrb;
    end
    if (bvalid_q && i_s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (do_wr) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = `BACM_RESP_OKAY;
      if (aw_far_q) begin
        bresp_d = `BACM_RESP_SLVERR;
      end else begin
        case (aw_ofs_q)
          `BACM_OFS_ADDR:   break_address_a_d = merge(break_address_a_q, wdata_q, wstrb_q);
          `BACM_OFS_AMASK:  break_address_mask_a_d =
                              merge(break_address_mask_a_q, wdata_q, wstrb_q);
          `BACM_OFS_CYCCTL: break_cycle_control_a_d = 16'(merge(
                              {16'h0, break_cycle_control_a_q}, wdata_q, wstrb_q))
                              & `BACM_CYCCTL_WMASK;
          `BACM_OFS_DATA:   break_compare_data_a_d =
                              merge(break_compare_data_a_q, wdata_q, wstrb_q);
          `BACM_OFS_DMASK:  break_data_mask_a_d =
                              merge(break_data_mask_a_q, wdata_q, wstrb_q);
          `BACM_OFS_STATUS: begin
            // Write one to clear
            if (wstrb_q[0] && wdata_q[`BACM_ST_SEEN]) begin
              seen_d = 1'b0;
            end
            if (wstrb_q[0] && wdata_q[`BACM_ST_IBUS]) begin
              last_ibus_d = 1'b0;
            end
          end
          default:          bresp_d = `BACM_RESP_SLVERR;
        endcase
      end
    end
    if (match_q) begin
      seen_d      = 1'b1;
      last_ibus_d = on_ibus_q;
    end
    // Each channel stays closed until its word is used and answered
    awready_d = !aw_have_d && !bvalid_d;
    wready_d  = !w_have_d && !bvalid_d;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      break_address_a_q       <= `BACM_RST_WORD;
      break_address_mask_a_q  <= `BACM_RST_WORD;
      break_cycle_control_a_q <= `BACM_RST_CYCCTL;
      break_compare_data_a_q  <= `BACM_RST_WORD;
      break_data_mask_a_q     <= `BACM_RST_WORD;
      seen_q                  <= 1'b0;
      last_ibus_q             <= 1'b0;
      aw_have_q               <= 1'b0;
      aw_ofs_q                <= 5'h00;
      aw_far_q                <= 1'b0;
      w_have_q                <= 1'b0;
      wdata_q                 <= 32'h0;
      wstrb_q                 <= 4'h0;
      awready_q               <= 1'b0;
      wready_q                <= 1'b0;
      bvalid_q                <= 1'b0;
      bresp_q                 <= `BACM_RESP_OKAY;
    end else begin
      break_address_a_q       <= break_address_a_d;
      break_address_mask_a_q  <= break_address_mask_a_d;
      break_cycle_control_a_q <= break_cycle_control_a_d;
      break_compare_data_a_q  <= break_compare_data_a_d;
      break_data_mask_a_q     <= break_data_mask_a_d;
      seen_q                  <= seen_d;
      last_ibus_q             <= last_ibus_d;
      aw_have_q               <= aw_have_d;
      aw_ofs_q                <= aw_ofs_d;
      aw_far_q                <= aw_far_d;
      w_have_q                <= w_have_d;
      wdata_q                 <= wdata_d;
      wstrb_q                 <= wstrb_d;
      awready_q               <= awready_d;
      wready_q                <= wready_d;
      bvalid_q                <= bvalid_d;
      bresp_q                 <= bresp_d;
    end
  end

  // Read path: one read in flight, data registered with its valid
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (rvalid_q && i_s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (i_s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d  = `BACM_RESP_OKAY;
      rdata_d  = 32'h0;
      if (|i_s_axi_araddr[ADDR_W-1:5]) begin
        rresp_d = `BACM_RESP_SLVERR;
      end else begin
        case ({i_s_axi_araddr[4:2], 2'b00})
          `BACM_OFS_ADDR:   rdata_d = break_address_a_q;
          `BACM_OFS_AMASK:  rdata_d = break_address_mask_a_q;
          `BACM_OFS_CYCCTL: rdata_d = {16'h0, break_cycle_control_a_q};
          `BACM_OFS_DATA:   rdata_d = break_compare_data_a_q;
          `BACM_OFS_DMASK:  rdata_d = break_data_mask_a_q;
          `BACM_OFS_STATUS: rdata_d = status_word;
          default:          rresp_d = `BACM_RESP_SLVERR;
        endcase
      end
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= `BACM_RESP_OKAY;
    end else begin
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // Comparators, one set per bus
  bacm_cyc_qual u_lqual (
    .i_ctrl  (cc),
    .i_fetch (i_lbus_fetch),
    .i_write (i_lbus_write),
    .i_size  (i_lbus_size),
    .o_ok    (lq_ok)
  );
  bacm_cyc_qual u_iqual (
    .i_ctrl  (cc),
    .i_fetch (i_ibus_fetch),
    .i_write (i_ibus_write),
    .i_size  (i_ibus_size),
    .o_ok    (iq_ok)
  );
  bacm_mask_cmp #(.WIDTH(32)) u_laddr (
    .i_value (i_local_address_bus),
    .i_ref   (break_address_a_q),
    .i_mask  (break_address_mask_a_q),
    .o_equal (la_eq)
  );
  bacm_mask_cmp #(.WIDTH(32)) u_iaddr (
    .i_value (i_internal_address_bus),
    .i_ref   (break_address_a_q),
    .i_mask  (break_address_mask_a_q),
    .o_equal (ia_eq)
  );
  bacm_mask_cmp #(.WIDTH(32)) u_ldata (
    .i_value (i_local_data_bus),
    .i_ref   (break_compare_data_a_q),
    .i_mask  (break_data_mask_a_q),
    .o_equal (ld_eq)
  );
  bacm_mask_cmp #(.WIDTH(32)) u_idata (
    .i_value (i_internal_data_bus),
    .i_ref   (break_compare_data_a_q),
    .i_mask  (break_data_mask_a_q),
    .o_equal (id_eq)
  );

  // Data takes part only once a size is set; a fetch must match on data as well
  assign data_on = (cc.size != `BACM_CODE_OFF);
  assign lb_sel  = (cc.bus == 2'h1) || (cc.bus == 2'h3);
  // Only processor cycles count on the internal bus
  assign ib_sel  = (cc.bus == 2'h2) && cc.master[0];
  assign lb_hit  = i_lbus_valid && lb_sel && lq_ok && la_eq
                   && (!data_on || ld_eq);
  assign ib_hit  = i_ibus_valid && i_ibus_cpu && ib_sel && iq_ok && ia_eq
                   && (!data_on || id_eq);

  always_comb begin
    match_d   = lb_hit || ib_hit;
    on_ibus_d = ib_hit;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      match_q   <= 1'b0;
      on_ibus_q <= 1'b0;
    end else begin
      match_q   <= match_d;
      on_ibus_q <= on_ibus_d;
    end
  end

  assign o_s_axi_awready = awready_q;
  assign o_s_axi_wready  = wready_q;
  assign o_s_axi_bvalid  = bvalid_q;
  assign o_s_axi_bresp   = bresp_q;
  assign o_s_axi_arready = arready_q;
  assign o_s_axi_rvalid  = rvalid_q;
  assign o_s_axi_rdata   = rdata_q;
  assign o_s_axi_rresp   = rresp_q;
  assign o_match_a       = match_q;
  assign o_match_on_ibus = on_ibus_q;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  local_hit_a: assert property (
    i_lbus_valid && cc.bus == 2'h3 && lq_ok && la_eq && !data_on
    |=> o_match_a && !o_match_on_ibus) else $error("local match missed");
  ibus_hit_a: assert property (
    i_ibus_valid && i_ibus_cpu && ib_sel && iq_ok && ia_eq && data_on && id_eq
    |=> o_match_a && o_match_on_ibus) else $error("internal match missed");
  field_off_a: assert property (
    cc.bus == 2'h0 || cc.access == 2'h0 || cc.dir == 2'h0 |=> !o_match_a)
    else $error("match with a disabled field");
  fetch_only_a: assert property (
    cc.access == 2'h1 && !i_lbus_fetch && !i_ibus_fetch |=> !o_match_a)
    else $error("data cycle matched fetch setting");
  read_only_a: assert property (
    cc.dir == 2'h1 && i_lbus_write && i_ibus_write |=> !o_match_a)
    else $error("write matched read setting");
  size_diff_a: assert property (
    data_on && i_lbus_size != cc.size && i_ibus_size != cc.size |=> !o_match_a)
    else $error("size mismatch matched");
  addr_mask_a: assert property (
    o_match_a && !o_match_on_ibus |-> ~|(($past(i_local_address_bus)
      ^ $past(break_address_a_q)) & ~$past(break_address_mask_a_q)))
    else $error("unmasked address bit differed");
  data_mask_a: assert property (
    o_match_a && o_match_on_ibus && $past(data_on) |-> ~|(($past(i_internal_data_bus)
      ^ $past(break_compare_data_a_q)) & ~$past(break_data_mask_a_q)))
    else $error("unmasked data bit differed");
  lbus_cause_a: assert property (
    o_match_a && !o_match_on_ibus |-> $past(i_lbus_valid) && $past(cc.bus[0]))
    else $error("local match without local cycle");
  data_reset_a: assert property (disable iff (1'b0)
    !i_rst_n |=> break_compare_data_a_q == 32'h0 && break_data_mask_a_q == 32'h0)
    else $error("data registers not cleared");

  cover property (o_match_a && !o_match_on_ibus);
  cover property (o_match_a && o_match_on_ibus);
  cover property (do_wr && aw_ofs_q == `BACM_OFS_CYCCTL);
  cover property (rvalid_q && i_s_axi_rready && rresp_q == `BACM_RESP_SLVERR);

endmodule

// ==== logic/bacm_cyc_qual.sv ====
`timescale 1ns/1ps
`include "bacm_defs.svh"

module bacm_cyc_qual (
  // Setup
  input  wire bacm_pkg::bacm_cyc_ctrl_s i_ctrl,
  // Bus cycle attributes
  input  wire logic                     i_fetch,
  input  wire logic                     i_write,
  input  wire bacm_pkg::bacm_code_t     i_size,
  // Result
  output logic                          o_ok
);
  import bacm_pkg::*;

  logic access_ok;
  logic dir_ok;
  logic size_ok;

  always_comb begin
    case (i_ctrl.access)
      2'h1:    access_ok = i_fetch;
      2'h2:    access_ok = !i_fetch;
      2'h3:    access_ok = 1'b1;
      default: access_ok = 1'b0;
    endcase
    case (i_ctrl.dir)
      2'h1:    dir_ok = !i_write;
      2'h2:    dir_ok = i_write;
      2'h3:    dir_ok = 1'b1;
      default: dir_ok = 1'b0;
    endcase
    // Size code 00 leaves the size out
    size_ok = (i_ctrl.size == `BACM_CODE_OFF) || (i_size == i_ctrl.size);
  end

  assign o_ok = access_ok && dir_ok && size_ok;

endmodule

// ==== logic/bacm_defs.svh ====
`ifndef BACM_DEFS_SVH
`define BACM_DEFS_SVH

// Byte offsets of the register words
`define BACM_OFS_ADDR    5'h00
`define BACM_OFS_AMASK   5'h04
`define BACM_OFS_CYCCTL  5'h08
`define BACM_OFS_DATA    5'h0c
`define BACM_OFS_DMASK   5'h10
`define BACM_OFS_STATUS  5'h14

// Reset values
`define BACM_RST_WORD    32'h0000_0000
`define BACM_RST_CYCCTL  16'h0000

// Writable bits of the cycle control word; 15 to 11 read as zero
`define BACM_CYCCTL_WMASK 16'h07ff

// Status word field positions
`define BACM_ST_SEEN     0
`define BACM_ST_IBUS     1

// Codes
`define BACM_CODE_OFF    2'h0
`define BACM_RESP_OKAY   2'h0
`define BACM_RESP_SLVERR 2'h2

`endif

// ==== logic/bacm_mask_cmp.sv ====
`timescale 1ns/1ps

module bacm_mask_cmp #(
  parameter int WIDTH = 32
) (
  // Operands
  input  wire logic [WIDTH-1:0] i_value,
  input  wire logic [WIDTH-1:0] i_ref,
  input  wire logic [WIDTH-1:0] i_mask,
  // Result
  output logic                  o_equal
);

  if (WIDTH < 1) begin : g_chk
    $error("bacm_mask_cmp: WIDTH must be positive");
  end

  // A mask bit of 1 leaves that bit out of the compare
  assign o_equal = ~|((i_value ^ i_ref) & ~i_mask);

endmodule

// ==== logic/bacm_pkg.sv ====
package bacm_pkg;

  typedef logic [1:0] bacm_code_t;

  // Layout of the cycle control word, most significant field first
  typedef struct packed {
    logic [4:0] rsvd;
    logic [2:0] master;
    bacm_code_t bus;
    bacm_code_t access;
    bacm_code_t dir;
    bacm_code_t size;
  } bacm_cyc_ctrl_s;

endpackage
